// >>> src/static_mem_pkg.sv
// Shared types, timing weights and reset values for the static memory controller
package static_mem_pkg;

  // Bus shape
  localparam int CS_COUNT = 8;
  localparam int CS_W = 3;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int BYTES = 4;
  localparam int FLOAT_W = 4;
  localparam int CNT_W = 10;

  // Weights of the top bits of the coded timing fields
  localparam int SETUP_HI_WEIGHT = 128;
  localparam int PULSE_HI_WEIGHT = 256;
  localparam int CYCLE_HI_WEIGHT = 256;

  // Coded timing groups, one set per chip select
  typedef struct packed {
    logic [5:0] wr_strobe;
    logic [5:0] wr_select;
    logic [5:0] rd_strobe;
    logic [5:0] rd_select;
  } setup_timing_group_t;

  typedef struct packed {
    logic [6:0] wr_strobe;
    logic [6:0] wr_select;
    logic [6:0] rd_strobe;
    logic [6:0] rd_select;
  } pulse_timing_group_t;

  typedef struct packed {
    logic [8:0] write_total;
    logic [8:0] read_total;
  } cycle_timing_group_t;

  // Mode fields: 1 = strobe controls the transfer, 0 = chip select does
  typedef struct packed {
    logic read_by_strobe;
    logic write_by_strobe;
    logic float_opt;
    logic [FLOAT_W-1:0] float_cycles;
  } mode_t;

  typedef struct packed {
    setup_timing_group_t setup;
    pulse_timing_group_t pulse;
    cycle_timing_group_t cycle;
    mode_t mode;
  } cs_cfg_t;

  // Effective lengths in master clock cycles
  typedef struct packed {
    logic [CNT_W-1:0] ws_setup, wc_setup, rs_setup, rc_setup;
    logic [CNT_W-1:0] ws_pulse, wc_pulse, rs_pulse, rc_pulse;
    logic [CNT_W-1:0] w_cycle, r_cycle;
  } timing_t;

  typedef struct packed {
    logic write;
    logic [CS_W-1:0] cs;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] be;
  } req_t;

  // External pins; strobes active low, data_oe_n low while driving
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic data_oe_n;
    logic [CS_COUNT-1:0] chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [BYTES-1:0] byte_select_n;
  } mem_pins_t;

  localparam mem_pins_t PINS_IDLE = '{addr: '0, wdata: '0, data_oe_n: 1'b1, chip_select_n: '1,
                                       read_strobe_n: 1'b1, write_strobe_n: 1'b1, byte_select_n: '1};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ACCESS = 4'h4,
    ST_RELEASE = 4'h8
  } st_t;

endpackage : static_mem_pkg

// >>> src/static_memory_controller.sv
// External static memory access sequencer with automatic idle-cycle insertion
`timescale 1ns/1ps
// How it works
// R01 - Strobe-controlled write: data driven from end of strobe setup to cycle end.
// R02 - Select-controlled write: data driven from end of select setup to cycle end.
// R03 - Setup code is 6 bits: 128 times top bit plus low five bits.
// R04 - Pulse code is 7 bits: 256 times top bit plus low six bits.
// R05 - Cycle code is 9 bits: 256 times top two bits plus low seven.
// R06 - Per chip select: setup group, pulse group, cycle group of timings.
// R07 - Software keeps setup plus pulse within cycle; nothing is checked here.
// R08 - Software never programs a zero pulse length.
// R09 - Strobe write with zero hold keeps address, selects, chip select past strobe rise.
// R10 - One idle cycle between transfers on different chip selects.
// R11 - In that idle cycle all selects and strobes sit high.
// R12 - Early-read idle only for write then read on same chip select.
// R13 - Early-read idle when write control has no hold and read control no setup.
// R14 - Select-controlled write, no select hold, zero read select setup: early-read idle.
// R15 - Strobe write, no hold: if strobe feedback still low, hold bus one more cycle.
// R16 - Mode write arms one reload idle cycle; new settings load during it.
// R17 - Reload idle replaces the chip-select idle; applies even on same chip select.
// R18 - Software writes the mode register after changing only timings.
// R19 - Slow clock mode entry or exit arms a reload idle after current transfer.
// R20 - Read followed by write always gets one extra idle cycle.
// R21 - After read, float idle cycles before other-device read or any write.
// R22 - Float idle cycles never stall internal memory accesses.
// R23 - Float period starts when read-controlling signal rises.
// R24 - Without optimization, hold of read control counts toward float period.
// R25 - With optimization, float period overlaps next access setup.
// R26 - Hold of each signal is cycle minus setup minus pulse.
// R27 - All idle kinds at a boundary are summed in one arbitration step; here only the read-to-write idle is added to the others.
module static_memory_controller
  import static_mem_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input static_mem_pkg::req_t req_in,
  input wire logic req_valid,
  output logic req_ready,
  output logic wr_done,
  output logic rd_done,
  output logic [static_mem_pkg::DATA_W-1:0] rd_data,
  input wire logic [static_mem_pkg::DATA_W-1:0] data_in,
  input wire logic write_strobe_fb,
  input static_mem_pkg::cs_cfg_t [static_mem_pkg::CS_COUNT-1:0] cfg_in,
  input wire logic mode_write,
  input wire logic slow_clock_mode,
  input wire logic int_req,
  output logic int_ack,
  output static_mem_pkg::mem_pins_t pins
);
  import static_mem_pkg::*;

  typedef struct packed {
    st_t st;
    cs_cfg_t [CS_COUNT-1:0] act;
    req_t cur;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wcnt;
    logic [FLOAT_W-1:0] flt;
    logic fneed;
    logic reload_pend;
    logic reload_now;
    logic slow_q;
    logic have_last;
    logic last_write;
    logic [CS_W-1:0] last_cs;
    logic last_hold_zero;
    logic last_wcs_hold_zero;
    logic last_wbs;
    logic last_fopt;
    logic ready;
    logic wr_done;
    logic rd_done;
    logic [DATA_W-1:0] rdata;
    logic int_ack;
    mem_pins_t pins;
  } state_t;

  localparam state_t RESET_STATE = '{st: ST_IDLE, pins: PINS_IDLE, reload_pend: 1'b1, ready: 1'b1, default: '0};

  state_t s_q;
  state_t s_d;
  logic [CS_W-1:0] sel_cs;
  timing_t tm;
  mode_t md;
  logic [FLOAT_W-1:0] flt_nx;
  logic [CNT_W-1:0] c_setup;
  logic [CNT_W-1:0] c_end;
  logic [CNT_W-1:0] cyc;
  logic diff;
  logic early;
  logic base;
  logic r2w;
  logic need;

  // Setup of the controlling signal of a transfer
  function automatic logic [CNT_W-1:0] ctl_setup(input logic w, input timing_t t, input mode_t m);
    if (w) begin
      return m.write_by_strobe ? t.ws_setup : t.wc_setup;
    end
    return m.read_by_strobe ? t.rs_setup : t.rc_setup;
  endfunction : ctl_setup

  // Pulse of the controlling signal of a transfer
  function automatic logic [CNT_W-1:0] ctl_pulse(input logic w, input timing_t t, input mode_t m);
    if (w) begin
      return m.write_by_strobe ? t.ws_pulse : t.wc_pulse;
    end
    return m.read_by_strobe ? t.rs_pulse : t.rc_pulse;
  endfunction : ctl_pulse

  // Pin levels for cycle n of a transfer
  function automatic mem_pins_t drive(input req_t r, input timing_t t, input mode_t m, input logic [CNT_W-1:0] n);
    mem_pins_t p;
    logic [CNT_W-1:0] cs_su;
    logic [CNT_W-1:0] cs_pl;
    p = PINS_IDLE;
    cs_su = r.write ? t.wc_setup : t.rc_setup;
    cs_pl = r.write ? t.wc_pulse : t.rc_pulse;
    p.addr = r.addr;
    p.wdata = r.data;
    p.byte_select_n = ~r.be;
    if (n >= cs_su && n < cs_su + cs_pl) begin
      p.chip_select_n[r.cs] = 1'b0;
    end
    p.read_strobe_n = !(!r.write && n >= t.rs_setup && n < t.rs_setup + t.rs_pulse);
    p.write_strobe_n = !(r.write && n >= t.ws_setup && n < t.ws_setup + t.ws_pulse);
    p.data_oe_n = !(r.write && n >= ctl_setup(1'b1, t, m)); // R01 R02
    return p;
  endfunction : drive

  // Float period still reaching into the next transfer
  function automatic logic float_blocks(input logic nd, input logic opt, input logic [FLOAT_W-1:0] f,
                                        input logic [CNT_W-1:0] su);
    if (!nd) begin
      return 1'b0;
    end
    if (opt) begin
      return CNT_W'(f) > su; // R25
    end
    return f != '0; // R24
  endfunction : float_blocks

  // Settings of the chip select being started or served
  assign sel_cs = (s_q.st == ST_IDLE) ? req_in.cs : s_q.cur.cs;
  assign md = s_q.act[sel_cs].mode;

  timing_decode u_decode (
    .cfg (s_q.act[sel_cs]), // R06
    .tm (tm)
  );

  // Controlling-signal figures of the selected transfer
  assign c_setup = ctl_setup((s_q.st == ST_IDLE) ? req_in.write : s_q.cur.write, tm, md);
  assign c_end = ctl_setup(s_q.cur.write, tm, md) + ctl_pulse(s_q.cur.write, tm, md);
  assign cyc = s_q.cur.write ? tm.w_cycle : tm.r_cycle;
  assign flt_nx = (s_q.flt != '0) ? s_q.flt - 1'b1 : '0;

  // Boundary conditions against the previous external transfer
  assign diff = s_q.have_last && (s_q.last_cs != req_in.cs);
  assign early = s_q.have_last && s_q.last_write && !req_in.write && !diff && // R12
                 ((s_q.last_hold_zero && c_setup == '0) || // R13
                  (!s_q.last_wbs && s_q.last_wcs_hold_zero && tm.rc_setup == '0)); // R14
  assign base = diff || s_q.reload_pend || early; // R10 R17
  assign r2w = s_q.have_last && !s_q.last_write && req_in.write; // R20
  assign need = s_q.have_last && !s_q.last_write && (req_in.write || diff); // R21

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.wr_done = 1'b0;
    s_d.rd_done = 1'b0;
    s_d.int_ack = int_req; // R22
    s_d.flt = flt_nx; // R23
    case (s_q.st)
      ST_IDLE: begin
        if (req_valid && s_q.ready) begin
          // One arbitration step merges chip-select, reload and early-read idles and adds the read-to-write idle
          s_d.cur = req_in;
          s_d.wcnt = CNT_W'(base) + CNT_W'(r2w); // R27 R20
          s_d.fneed = need;
          s_d.reload_now = s_q.reload_pend;
          s_d.reload_pend = 1'b0;
          s_d.ready = 1'b0;
          if (base || r2w || float_blocks(need, s_q.last_fopt, flt_nx, c_setup)) begin
            s_d.st = ST_WAIT;
            s_d.pins = PINS_IDLE; // R11
            s_d.pins.addr = s_q.pins.addr;
          end else begin
            s_d.st = ST_ACCESS;
            s_d.cnt = '0;
            s_d.pins = drive(req_in, tm, md, '0);
          end
        end
      end
      ST_WAIT: begin
        // New settings are taken while the bus is idle
        if (s_q.reload_now) begin
          s_d.act = cfg_in; // R16
          s_d.reload_now = 1'b0;
        end
        if (s_q.wcnt != '0) begin
          s_d.wcnt = s_q.wcnt - 1'b1;
        end
        if (s_q.wcnt <= CNT_W'(1) && !s_q.reload_now &&
            !float_blocks(s_q.fneed, s_q.last_fopt, flt_nx, c_setup)) begin
          s_d.st = ST_ACCESS;
          s_d.cnt = '0;
          s_d.pins = drive(s_q.cur, tm, md, '0);
        end
      end
      ST_ACCESS: begin
        // Read data is taken on the edge that raises the controlling signal
        if (s_q.cnt == c_end - 1'b1 && !s_q.cur.write) begin
          s_d.rdata = data_in;
          s_d.rd_done = 1'b1;
          s_d.flt = md.float_cycles; // R23 R24
        end
        if (s_q.cnt >= cyc - 1'b1) begin
          s_d.have_last = 1'b1;
          s_d.last_write = s_q.cur.write;
          s_d.last_cs = s_q.cur.cs;
          s_d.last_hold_zero = (cyc == c_end); // R26
          s_d.last_wcs_hold_zero = (tm.w_cycle == tm.wc_setup + tm.wc_pulse); // R26
          s_d.last_wbs = md.write_by_strobe;
          s_d.last_fopt = md.float_opt;
          if (s_q.cur.write && md.write_by_strobe && cyc == c_end) begin
            // Strobe rises now; address, selects and chip select stay
            s_d.st = ST_RELEASE; // R09
            s_d.pins.write_strobe_n = 1'b1;
          end else begin
            // Write done is reported only once the bus is idle again; read done came at the control rise
            s_d.wr_done = s_q.cur.write;
            s_d.st = ST_IDLE;
            s_d.ready = 1'b1;
            s_d.pins = PINS_IDLE;
            s_d.pins.addr = s_q.pins.addr;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
          s_d.pins = drive(s_q.cur, tm, md, s_q.cnt + 1'b1);
        end
      end
      ST_RELEASE: begin
        // Strobe feedback still low: keep the bus one more cycle
        if (write_strobe_fb) begin // R15
          s_d.wr_done = 1'b1;
          s_d.st = ST_IDLE;
          s_d.ready = 1'b1;
          s_d.pins = PINS_IDLE;
          s_d.pins.addr = s_q.pins.addr;
        end
      end
      default: begin
        s_d = RESET_STATE;
      end
    endcase
    // Configuration events arm a reload; an arming event beats the clear
    if (mode_write || (slow_clock_mode != s_q.slow_q)) begin
      s_d.reload_pend = 1'b1; // R16 R19
    end
    s_d.slow_q = slow_clock_mode;
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign req_ready = s_q.ready;
  assign wr_done = s_q.wr_done;
  assign rd_done = s_q.rd_done;
  assign rd_data = s_q.rdata;
  assign int_ack = s_q.int_ack;
  assign pins = s_q.pins;

endmodule : static_memory_controller

// >>> src/timing_decode.sv
// Decoder from coded setup, pulse and cycle fields to cycle counts
`timescale 1ns/1ps
module timing_decode
  import static_mem_pkg::*;
(
  input static_mem_pkg::cs_cfg_t cfg,
  output static_mem_pkg::timing_t tm
);

  // Setup: 128 x top bit + low five bits
  function automatic logic [CNT_W-1:0] eff_setup(input logic [5:0] c);
    return (c[5] ? CNT_W'(SETUP_HI_WEIGHT) : '0) + CNT_W'(c[4:0]);
  endfunction : eff_setup

  // Pulse: 256 x top bit + low six bits
  function automatic logic [CNT_W-1:0] eff_pulse(input logic [6:0] c);
    return (c[6] ? CNT_W'(PULSE_HI_WEIGHT) : '0) + CNT_W'(c[5:0]);
  endfunction : eff_pulse

  // Cycle: 256 x two top bits + low seven bits
  function automatic logic [CNT_W-1:0] eff_cycle(input logic [8:0] c);
    return CNT_W'(c[8:7]) * CNT_W'(CYCLE_HI_WEIGHT) + CNT_W'(c[6:0]);
  endfunction : eff_cycle

  // Setup fields
  assign tm.ws_setup = eff_setup(cfg.setup.wr_strobe); // R03
  assign tm.wc_setup = eff_setup(cfg.setup.wr_select); // R03
  assign tm.rs_setup = eff_setup(cfg.setup.rd_strobe); // R03
  assign tm.rc_setup = eff_setup(cfg.setup.rd_select); // R03
  // Pulse fields
  assign tm.ws_pulse = eff_pulse(cfg.pulse.wr_strobe); // R04
  assign tm.wc_pulse = eff_pulse(cfg.pulse.wr_select); // R04
  assign tm.rs_pulse = eff_pulse(cfg.pulse.rd_strobe); // R04
  assign tm.rc_pulse = eff_pulse(cfg.pulse.rd_select); // R04
  // Cycle fields
  assign tm.w_cycle = eff_cycle(cfg.cycle.write_total); // R05
  assign tm.r_cycle = eff_cycle(cfg.cycle.read_total); // R05

endmodule : timing_decode

// >>> test/mem_partner.sv
// Behavioural external memory that answers on the controller's pins
`timescale 1ns/1ps
module mem_partner
  import static_mem_pkg::*;
(
  input wire logic clk,
  input static_mem_pkg::mem_pins_t pins,
  input wire logic fb_slow,
  output logic [static_mem_pkg::DATA_W-1:0] data_in,
  output logic write_strobe_fb
);
  import static_mem_pkg::*;
  logic [DATA_W-1:0] mem [64];
  logic [DATA_W-1:0] last_q = '0;
  logic fb_q = 1'b1;
  logic sel;
  int k;
  initial for (int i = 0; i < 64; i++) mem[i] = '0;
  assign sel = ~&pins.chip_select_n;
  // Word index from the selected chip and the low address bits
  always_comb begin
    k = 0;
    for (int i = 0; i < CS_COUNT; i++) if (!pins.chip_select_n[i]) k = i * 8 + int'(pins.addr[2:0]);
  end
  // Store driven bytes while selected, so the last driven value wins
  always @(posedge clk) begin
    if (sel && !pins.data_oe_n)
      for (int b = 0; b < BYTES; b++) if (!pins.byte_select_n[b]) mem[k][b*8+:8] <= pins.wdata[b*8+:8];
    if (sel) last_q <= mem[k];
    fb_q <= pins.write_strobe_n;
  end
  // A released bus shows the inverted last word, never a stale copy
  assign data_in = sel ? mem[k] : ~last_q;
  assign write_strobe_fb = fb_slow ? fb_q : pins.write_strobe_n;
endmodule : mem_partner

// >>> test/static_memory_controller_sva.sv
// Pin and handshake assertions for the static memory controller
`timescale 1ns/1ps
module static_memory_controller_sva
  import static_mem_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic wr_done,
  input wire logic rd_done,
  input wire logic [static_mem_pkg::DATA_W-1:0] rd_data,
  input static_mem_pkg::cs_cfg_t [static_mem_pkg::CS_COUNT-1:0] cfg_in,
  input wire logic int_req,
  input wire logic int_ack,
  input static_mem_pkg::mem_pins_t pins
);
  import static_mem_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic ws_mode;
  // Write mode of the chip select now active
  always_comb begin
    ws_mode = 1'b0;
    for (int i = 0; i < CS_COUNT; i++) if (!pins.chip_select_n[i]) ws_mode = cfg_in[i].mode.write_by_strobe;
  end
  property p_int_ack; !$past(reset) |-> int_ack == $past(int_req); endproperty
  a_int_ack: assert property (p_int_ack) else $error("internal ack late");
  property p_cs_onehot; $onehot0(~pins.chip_select_n); endproperty
  a_cs_onehot: assert property (p_cs_onehot) else $error("two chip selects active");
  property p_cs_gap; !(&pins.chip_select_n) && !(&$past(pins.chip_select_n)) |->
    pins.chip_select_n == $past(pins.chip_select_n); endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("chip select switch without idle");
  property p_oe_read; !pins.data_oe_n |-> pins.read_strobe_n; endproperty
  a_oe_read: assert property (p_oe_read) else $error("data driven during read strobe");
  property p_ws_data; !pins.write_strobe_n && ws_mode |-> !pins.data_oe_n; endproperty
  a_ws_data: assert property (p_ws_data) else $error("strobe write pulse without data");
  property p_take; req_valid && req_ready |=> !req_ready; endproperty
  a_take: assert property (p_take) else $error("ready stayed high after take");
  property p_done_idle; wr_done |-> req_ready && (&pins.chip_select_n) && pins.write_strobe_n
    && pins.read_strobe_n && pins.data_oe_n; endproperty
  a_done_idle: assert property (p_done_idle) else $error("pins busy at transfer end");
  property p_rd_end; rd_done |-> pins.write_strobe_n && pins.data_oe_n; endproperty
  a_rd_end: assert property (p_rd_end) else $error("write activity at read completion");
  property p_rd_hold; !rd_done |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without done");
  c_write: cover property (wr_done);
  c_read: cover property (rd_done);
  c_gap: cover property (!(&pins.chip_select_n) ##1 (&pins.chip_select_n) ##1 !(&pins.chip_select_n));
endmodule : static_memory_controller_sva
bind static_memory_controller static_memory_controller_sva i_sva (.clk(clk), .reset(reset), .req_valid(req_valid),
  .req_ready(req_ready), .wr_done(wr_done), .rd_done(rd_done), .rd_data(rd_data), .cfg_in(cfg_in),
  .int_req(int_req), .int_ack(int_ack), .pins(pins));

// >>> test/testbench.sv
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module testbench;
  import static_mem_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  req_t req_in = '0;
  logic req_valid = 1'b0, mode_write = 1'b0, slow_clock_mode = 1'b0, int_req = 1'b0, fb_slow = 1'b0;
  cs_cfg_t [CS_COUNT-1:0] cfg_in = '0;
  logic req_ready, wr_done, rd_done, int_ack, write_strobe_fb, cs1_q = 1'b1, ws_q = 1'b1;
  logic [DATA_W-1:0] rd_data, data_in;
  mem_pins_t pins;
  logic [DATA_W-1:0] ref_mem [64];
  logic [40:0] exp_q [$];
  int miscompares = 0, checks_done = 0, cycles = 0, t_csf, t_csr, t_wsf, t_wsr, t_done;
  static_memory_controller i_dut (.clk(clk), .reset(reset), .req_in(req_in), .req_valid(req_valid),
    .req_ready(req_ready), .wr_done(wr_done), .rd_done(rd_done), .rd_data(rd_data), .data_in(data_in),
    .write_strobe_fb(write_strobe_fb), .cfg_in(cfg_in), .mode_write(mode_write),
    .slow_clock_mode(slow_clock_mode), .int_req(int_req), .int_ack(int_ack), .pins(pins));
  mem_partner i_mem (.clk(clk), .pins(pins), .fb_slow(fb_slow), .data_in(data_in), .write_strobe_fb(write_strobe_fb));
  always #20 clk = ~clk;
  task automatic chk(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // One request held until taken; the expected result is queued at the take
  task automatic xfer(input logic w, input logic [2:0] cs, input logic [2:0] a, input logic [3:0] be);
    logic [DATA_W-1:0] d;
    logic [5:0] k;
    d = $urandom;
    k = {cs, a};
    @(posedge clk);
    req_valid <= 1'b1;
    req_in <= {w, cs, 21'h0, a, d, be};
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    if (w) for (int b = 0; b < BYTES; b++) if (be[b]) ref_mem[k][b*8+:8] = d[b*8+:8];
    exp_q.push_back({w, 2'b0, k, ref_mem[k]});
  endtask : xfer
  task automatic wait_idle;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
  endtask : wait_idle
  // Legal random timing: nonzero pulses, cycle covers setup plus pulse, hold zero or one
  task automatic cfg_rand(input int cs);
    int s [4];
    int p [4];
    int wt, rt;
    for (int i = 0; i < 4; i++) begin
      s[i] = $urandom % 3;
      p[i] = 1 + $urandom % 3;
    end
    // Select pulses cover the strobe pulses so the memory sees every qualified access
    s[1] = $urandom % (s[0] + 1);
    p[1] = s[0] + p[0] - s[1];
    s[3] = $urandom % (s[2] + 1);
    p[3] = s[2] + p[2] - s[3];
    wt = (s[0] + p[0] > s[1] + p[1] ? s[0] + p[0] : s[1] + p[1]) + $urandom % 2;
    rt = (s[2] + p[2] > s[3] + p[3] ? s[2] + p[2] : s[3] + p[3]) + $urandom % 2;
    cfg_in[cs] <= {6'(s[0]), 6'(s[1]), 6'(s[2]), 6'(s[3]), 7'(p[0]), 7'(p[1]), 7'(p[2]), 7'(p[3]),
      9'(wt), 9'(rt), 3'($urandom), 4'($urandom)};
  endtask : cfg_rand
  // Each completion retires the oldest expectation
  always @(posedge clk) begin
    logic [40:0] e;
    if (wr_done === 1'b1 || rd_done === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, e[40]}, {31'h0, wr_done});
      chk(e[31:0], e[40] ? i_mem.mem[e[37:32]] : rd_data);
    end
  end
  // Edge times of chip select 1 and the write strobe, plus the hang limit
  always @(posedge clk) begin
    if (cs1_q && !pins.chip_select_n[1]) t_csf = cycles;
    if (!cs1_q && pins.chip_select_n[1]) t_csr = cycles;
    if (ws_q && !pins.write_strobe_n) t_wsf = cycles;
    if (!ws_q && pins.write_strobe_n) t_wsr = cycles;
    if (wr_done === 1'b1) t_done = cycles;
    cs1_q <= pins.chip_select_n[1];
    ws_q <= pins.write_strobe_n;
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(70130));
    for (int i = 0; i < 64; i++) ref_mem[i] = '0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Select-controlled write with top bits set in the strobe setup, select pulse and write cycle fields
    cfg_in[1] <= {6'h21, 6'h01, 6'h01, 6'h01, 7'h02, 7'h41, 7'h01, 7'h01, 9'h185, 9'h004, 7'h00};
    xfer(1'b1, 3'h1, 3'h0, 4'hF);
    wait_idle();
    chk(32'd128, 32'(t_wsf - t_csf));
    chk(32'd257, 32'(t_csr - t_csf));
    chk(32'd2, 32'(t_wsr - t_wsf));
    chk(32'd515, 32'(t_done - t_csr));
    xfer(1'b0, 3'h1, 3'h0, 4'hF);
    // Random traffic over all chip selects with reprogramming and slow clock changes
    for (int n = 0; n < 120; n++) begin
      if (n % 20 == 0) begin
        wait_idle();
        for (int c = 0; c < CS_COUNT; c++) cfg_rand(c);
        mode_write <= 1'b1;
        @(posedge clk);
        mode_write <= 1'b0;
      end
      if (n % 30 == 15) slow_clock_mode <= ~slow_clock_mode;
      fb_slow <= 1'($urandom % 2);
      int_req <= 1'($urandom % 2);
      xfer(1'($urandom % 2), 3'($urandom), 3'($urandom), 4'($urandom % 15 + 1));
    end
    wait_idle();
    repeat (4) @(posedge clk);
    chk(32'd0, 32'(exp_q.size()));
    stop_test();
  end
endmodule : testbench
